// >>> hw/tdm_params.svh
// Constants for the transmitter device-management command block
`ifndef TDM_PARAMS_SVH
`define TDM_PARAMS_SVH
`define TDM_CLK_HZ 100000000
`define TDM_CMD_FIX_CUR 8'h28
`define TDM_CMD_SELF_TEST 8'h29
`define TDM_CMD_DEV_RESET 8'h2a
`define TDM_CMD_PV_DAMP 8'h22
`define TDM_CMD_DV_DAMP 8'h37
`define TDM_CMD_WP_WRITE 8'hc8
`define TDM_CMD_WP_READ 8'hc9
`define TDM_RSP_OK 8'h00
`define TDM_RSP_WP_ERR 8'h07
`define TDM_RSP_BAD_VAR 8'h02
`define TDM_RSP_MIN_MS 10
`define TDM_RSP_TYP_MS 20
`define TDM_RSP_MAX_MS 150
`define TDM_COMMIT_S 10
`define TDM_BOOT_S 2
`define TDM_SAMPLE_PER_S 50
`define TDM_LOOP_COMMIT_UA 16'd12000
`define TDM_LOOP_BOOT_UA 16'd4000
`define TDM_WP_RESET 1'b0
`define TDM_SELFTEST_BITS 8
`endif

// >>> hw/tdm_pkg.sv
// Types for the transmitter device-management command block
package tdm_pkg;
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b011,
        ST_ANSWER = 3'b010
    } tdm_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [7:0] arg;
        logic [7:0] data;
    } tdm_cmd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [7:0] code;
        logic [7:0] data;
    } tdm_rsp_t;

    typedef struct packed {
        logic cfg_tx;
        logic cfg_link;
        logic float1;
        logic float2;
        logic temp;
        logic thick;
        logic err_cnt;
        logic supply;
    } tdm_health_t;
endpackage

// >>> hw/tdm_core.sv
// Device-management command interpreter for a loop-powered level transmitter
// Contract
// - A device reset command restarts through the power-up path.
// - Self-test runs at power-up, on command and in background.
// - Self-test checks configs, floats, temp, thickness, errors, supply.
// - The sampling strobe sample_stb runs at fifty per second.
// - Answers go out 10 ms to 150 ms after the command, 20 ms typical.
// - The self-test command never blocks command handling.
// - Commit comes about 10 s after the last write; writes restart it.
// - Loop current is held at 12 mA while a commit is running.
// - One command sets write protection and another reads it back.
// - Write protection is off after reset.
// - Fixed current, self-test and reset work under write protection.
// - Damping only for the two floats, via either damping command.
// - At power-up config is loaded and checked, loop held at 4 mA.
// - The link opens about 2 s after power-up or reset restart.
// - A restart cancels fixed current mode and any temporary lock.
`timescale 1ns/1ps
`include "tdm_params.svh"
module tdm_core #(
    parameter int unsigned BOOT_CYC = `TDM_BOOT_S * `TDM_CLK_HZ,
    parameter int unsigned COMMIT_CYC = `TDM_COMMIT_S * `TDM_CLK_HZ,
    parameter int unsigned RSP_CYC = `TDM_RSP_TYP_MS * (`TDM_CLK_HZ / 1000),
    parameter int unsigned SAMPLE_CYC = `TDM_CLK_HZ / `TDM_SAMPLE_PER_S
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input tdm_pkg::tdm_cmd_t cmd_in,
    output logic cmd_ready,
    output tdm_pkg::tdm_rsp_t rsp_out,
    input tdm_pkg::tdm_health_t health_in,
    input wire logic cfg_load_done,
    output logic cfg_load_req,
    output logic nvm_commit_req,
    input wire logic nvm_commit_busy,
    output logic sample_stb,
    output logic loop_fixed,
    output logic [15:0] loop_fixed_ua,
    output logic link_up,
    output logic write_protect,
    output logic cfg_write_stb,
    output logic [7:0] damp_var,
    output logic [7:0] damp_val,
    output logic fixed_cur_mode,
    output logic temp_lock_clr,
    output tdm_pkg::tdm_health_t selftest_fault,
    output logic selftest_busy
);
    import tdm_pkg::*;

    typedef struct packed {
        tdm_state_t st;
        logic [31:0] boot_cnt;
        logic [31:0] rsp_cnt;
        logic [31:0] commit_cnt;
        logic commit_pend;
        logic [31:0] samp_cnt;
        logic samp;
        logic wp;
        logic fixed;
        logic cfg_req;
        logic commit;
        logic wr;
        logic [7:0] dvar;
        logic [7:0] dval;
        tdm_cmd_t cmd;
        tdm_rsp_t rsp;
        tdm_health_t fault;
        logic st_busy;
        logic lock_clr;
    } tdm_reg_t;

    tdm_reg_t s_q;
    tdm_reg_t s_d;

    localparam int unsigned RSP_MIN =
        `TDM_RSP_MIN_MS * (`TDM_CLK_HZ / 1000);
    localparam int unsigned RSP_MAX =
        `TDM_RSP_MAX_MS * (`TDM_CLK_HZ / 1000);
    localparam int unsigned RSP_USE =
        (RSP_CYC < 1) ? 1 : RSP_CYC;

    function automatic logic is_cfg_write(input logic [7:0] c);
        is_cfg_write = (c == `TDM_CMD_PV_DAMP) || (c == `TDM_CMD_DV_DAMP);
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.wr = 1'b0;
        s_d.lock_clr = 1'b0;
        s_d.rsp.valid = 1'b0;
        // Background self-test of every health item
        s_d.fault = ~health_in;
        if (s_q.samp_cnt >= SAMPLE_CYC - 1) begin
            s_d.samp_cnt = 32'h0000_0000;
            s_d.samp = 1'b1;
        end else begin
            s_d.samp_cnt = s_q.samp_cnt + 32'h0000_0001;
            s_d.samp = 1'b0;
        end
        // Commit delay after last write
        if (s_q.commit && !nvm_commit_busy) begin
            s_d.commit = 1'b0;
        end
        if (s_q.commit_pend) begin
            if (s_q.commit_cnt >= COMMIT_CYC - 1) begin
                s_d.commit_pend = 1'b0;
                s_d.commit = 1'b1;
            end else begin
                s_d.commit_cnt = s_q.commit_cnt + 32'h0000_0001;
            end
        end
        unique case (s_q.st)
            ST_BOOT: begin
                s_d.fixed = 1'b0;
                s_d.st_busy = 1'b1;
                if (cfg_load_done) begin
                    s_d.cfg_req = 1'b0;
                end
                if (s_q.boot_cnt >= BOOT_CYC - 1 && !s_q.cfg_req) begin
                    s_d.st = ST_IDLE;
                    s_d.st_busy = 1'b0;
                end else if (s_q.boot_cnt < BOOT_CYC - 1) begin
                    s_d.boot_cnt = s_q.boot_cnt + 32'h0000_0001;
                end
            end
            ST_IDLE: begin
                if (cmd_in.valid) begin
                    s_d.cmd = cmd_in;
                    s_d.rsp_cnt = 32'h0000_0000;
                    s_d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (s_q.rsp_cnt >= RSP_USE - 1) begin
                    s_d.st = ST_ANSWER;
                end else begin
                    s_d.rsp_cnt = s_q.rsp_cnt + 32'h0000_0001;
                end
            end
            ST_ANSWER: begin
                s_d.rsp.valid = 1'b1;
                s_d.rsp.cmd = s_q.cmd.cmd;
                s_d.rsp.code = `TDM_RSP_OK;
                s_d.rsp.data = 8'h00;
                s_d.st = ST_IDLE;
                unique case (s_q.cmd.cmd)
                    `TDM_CMD_WP_WRITE: begin
                        s_d.wp = s_q.cmd.arg[0];
                        s_d.rsp.data = {7'h00, s_q.cmd.arg[0]};
                    end
                    `TDM_CMD_WP_READ: begin
                        s_d.rsp.data = {7'h00, s_q.wp};
                    end
                    `TDM_CMD_FIX_CUR: begin
                        s_d.fixed = s_q.cmd.arg[0];
                    end
                    `TDM_CMD_SELF_TEST: begin
                        s_d.rsp.data = {7'h00, |s_q.fault};
                    end
                    `TDM_CMD_DEV_RESET: begin
                        // Restart goes through the power-up path
                        s_d.st = ST_BOOT;
                        s_d.boot_cnt = 32'h0000_0000;
                        s_d.cfg_req = 1'b1;
                        s_d.commit_pend = 1'b0;
                        s_d.fixed = 1'b0;
                        s_d.lock_clr = 1'b1;
                        s_d.wp = `TDM_WP_RESET;
                    end
                    default: begin
                        if (is_cfg_write(s_q.cmd.cmd)) begin
                            if (s_q.wp) begin
                                s_d.rsp.code = `TDM_RSP_WP_ERR;
                            end else if (s_q.cmd.arg > 8'h01) begin
                                s_d.rsp.code = `TDM_RSP_BAD_VAR;
                            end else begin
                                s_d.wr = 1'b1;
                                s_d.dvar = s_q.cmd.arg;
                                s_d.dval = s_q.cmd.data;
                                s_d.commit_pend = 1'b1;
                                s_d.commit_cnt = 32'h0000_0000;
                            end
                        end
                    end
                endcase
            end
            default: begin
                s_d.st = ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.st <= ST_BOOT;
            s_q.cfg_req <= 1'b1;
            s_q.st_busy <= 1'b1;
            s_q.wp <= `TDM_WP_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign cmd_ready = (s_q.st == ST_IDLE);
    assign rsp_out = s_q.rsp;
    assign cfg_load_req = s_q.cfg_req;
    assign nvm_commit_req = s_q.commit;
    assign sample_stb = s_q.samp;
    assign loop_fixed = (s_q.st == ST_BOOT) || s_q.commit || nvm_commit_busy;
    // Commit clamp takes precedence over the boot level
    assign loop_fixed_ua = (s_q.commit || nvm_commit_busy) ?
        `TDM_LOOP_COMMIT_UA : `TDM_LOOP_BOOT_UA;
    assign link_up = (s_q.st != ST_BOOT);
    assign write_protect = s_q.wp;
    assign cfg_write_stb = s_q.wr;
    assign damp_var = s_q.dvar;
    assign damp_val = s_q.dval;
    assign fixed_cur_mode = s_q.fixed;
    assign temp_lock_clr = s_q.lock_clr;
    assign selftest_fault = s_q.fault;
    assign selftest_busy = s_q.st_busy;
endmodule

// >>> verification/tdm_core_props.sv
// Checker for the device-management command block
`timescale 1ns/1ps
`include "tdm_params.svh"
module tdm_core_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input tdm_pkg::tdm_cmd_t cmd_in,
    input wire logic cmd_ready,
    input tdm_pkg::tdm_rsp_t rsp_out,
    input wire logic nvm_commit_req,
    input wire logic sample_stb,
    input wire logic loop_fixed,
    input wire logic [15:0] loop_fixed_ua,
    input wire logic link_up,
    input wire logic write_protect,
    input wire logic cfg_write_stb,
    input wire logic [7:0] damp_var,
    input wire logic fixed_cur_mode,
    input wire logic temp_lock_clr
);
    import tdm_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire take = cmd_in.valid && cmd_ready;
    sequence s_answer;
        ##[20:23] rsp_out.valid;
    endsequence
    sequence s_quiet;
        !rsp_out.valid [*8];
    endsequence
    a_rsp_window: assert property (take |-> s_answer)
        else $error("answer outside window");
    a_rsp_early: assert property (take |=> s_quiet)
        else $error("answer too early");
    a_wp_source: assert property ($changed(write_protect) |->
        temp_lock_clr || (rsp_out.valid &&
        rsp_out.cmd inside {`TDM_CMD_WP_WRITE, `TDM_CMD_DEV_RESET}))
        else $error("protection changed without command");
    a_commit_clamp: assert property (nvm_commit_req |->
        loop_fixed && loop_fixed_ua == `TDM_LOOP_COMMIT_UA)
        else $error("no clamp");
    a_boot_clamp: assert property (!link_up |-> loop_fixed &&
        loop_fixed_ua == `TDM_LOOP_BOOT_UA) else $error("no boot clamp");
    a_wp_refuse: assert property (rsp_out.valid && write_protect &&
        rsp_out.cmd inside {`TDM_CMD_PV_DAMP, `TDM_CMD_DV_DAMP} |->
        rsp_out.code == `TDM_RSP_WP_ERR && !cfg_write_stb)
        else $error("protected write not refused");
    a_damp_var: assert property (cfg_write_stb |-> rsp_out.valid &&
        damp_var < 8'h02) else $error("damping on bad variable");
    a_sample_gap: assert property (sample_stb |=> !sample_stb [*8])
        else $error("sample strobe too fast");
    a_restart_clr: assert property (temp_lock_clr |->
        ##[0:2] (!link_up && !fixed_cur_mode))
        else $error("restart kept mode");
endmodule
bind tdm_core tdm_core_props u_props (.core_clk, .sys_rst, .cmd_in,
    .cmd_ready, .rsp_out, .nvm_commit_req, .sample_stb, .loop_fixed,
    .loop_fixed_ua, .link_up, .write_protect, .cfg_write_stb, .damp_var,
    .fixed_cur_mode, .temp_lock_clr);

// >>> verification/tdm_master.sv
// Master model issuing one command at a time
`timescale 1ns/1ps
module tdm_master (
    input wire logic core_clk,
    input wire logic cmd_ready,
    input tdm_pkg::tdm_rsp_t rsp_out,
    output tdm_pkg::tdm_cmd_t cmd_in
);
    import tdm_pkg::*;
    int lat;
    int misses;
    initial begin
        cmd_in = '0;
        misses = 0;
    end
    // Next command only after the previous answer
    task automatic send(input logic [7:0] c, input logic [7:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        while (!cmd_ready && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        if (!cmd_ready) begin
            misses++;
        end
        cmd_in = {1'b1, c, a, d};
        @(negedge core_clk);
        cmd_in = {1'b0, ~c, ~a, ~d};
        lat = 0;
        while (!rsp_out.valid && lat < 200) begin
            @(negedge core_clk);
            lat++;
        end
        if (!rsp_out.valid) begin
            misses++;
        end
    endtask
endmodule

// >>> verification/transmitter_device_mgmt_cmds_tb.sv
// Self-checking bench for the device-management command block
`timescale 1ns/1ps
`include "tdm_params.svh"
module transmitter_device_mgmt_cmds_tb;
    import tdm_pkg::*;
    logic core_clk, sys_rst, clk_en, cfg_load_done;
    logic nvm_commit_busy = 1'b0;
    logic cmd_ready, cfg_load_req, nvm_commit_req, sample_stb, loop_fixed;
    logic link_up, write_protect, cfg_write_stb, fixed_cur_mode;
    logic temp_lock_clr, selftest_busy;
    logic [15:0] loop_fixed_ua;
    logic [7:0] damp_var, damp_val;
    tdm_cmd_t cmd_in;
    tdm_rsp_t rsp_out;
    tdm_health_t health_in, selftest_fault;
    int bad_count, checks_done, wn;
    int bc = 0;
    tdm_core #(.BOOT_CYC(50), .COMMIT_CYC(200), .RSP_CYC(20),
        .SAMPLE_CYC(10)) dut (.core_clk, .sys_rst, .clk_en, .cmd_in,
        .cmd_ready, .rsp_out, .health_in, .cfg_load_done, .cfg_load_req,
        .nvm_commit_req, .nvm_commit_busy, .sample_stb, .loop_fixed,
        .loop_fixed_ua, .link_up, .write_protect, .cfg_write_stb,
        .damp_var, .damp_val, .fixed_cur_mode, .temp_lock_clr,
        .selftest_fault, .selftest_busy);
    tdm_master m (.core_clk, .cmd_ready, .rsp_out, .cmd_in);
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        bc <= nvm_commit_req ? bc + 1 : 0;
        nvm_commit_busy <= nvm_commit_req && bc < 4;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        bad_count = bad_count + m.misses;
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wait_up;
        wn = 0;
        while (!(link_up && cmd_ready) && wn < 500) begin
            @(negedge core_clk);
            wn++;
        end
    endtask
    task t_protect;
        m.send(`TDM_CMD_WP_READ, 8'h00, 8'h00);
        chk(rsp_out.data[0], 1'b0);
        m.send(`TDM_CMD_WP_WRITE, 8'h01, 8'h00);
        m.send(`TDM_CMD_WP_READ, 8'h00, 8'h00);
        chk(rsp_out.data[0], 1'b1);
        m.send(`TDM_CMD_PV_DAMP, 8'h00, 8'h03);
        chk(rsp_out.code, `TDM_RSP_WP_ERR);
        chk({cfg_write_stb, damp_val}, 9'h000);
        m.send(`TDM_CMD_FIX_CUR, 8'h01, 8'h00);
        chk({rsp_out.code, fixed_cur_mode}, 9'h001);
        m.send(`TDM_CMD_DEV_RESET, 8'h00, 8'h00);
        chk({temp_lock_clr, link_up}, 2'b10);
        wait_up;
        chk(wn >= 49 && wn < 70, 1'b1);
        chk({write_protect, fixed_cur_mode}, 2'b00);
    endtask
    task t_damp;
        int n;
        m.send(`TDM_CMD_DV_DAMP, 8'h01, 8'h05);
        chk({rsp_out.code, damp_var, damp_val}, 24'h000105);
        chk(cfg_write_stb, 1'b1);
        m.send(`TDM_CMD_PV_DAMP, 8'h03, 8'h05);
        chk(rsp_out.code, `TDM_RSP_BAD_VAR);
        chk({cfg_write_stb, damp_var, damp_val}, 17'h00105);
        repeat (80) @(negedge core_clk);
        m.send(`TDM_CMD_PV_DAMP, 8'h00, 8'h02);
        n = 0;
        while (!nvm_commit_req && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk(n > 190 && n < 210, 1'b1);
        chk(loop_fixed_ua, `TDM_LOOP_COMMIT_UA);
        repeat (20) @(negedge core_clk);
    endtask
    task t_self;
        health_in = 8'hfb;
        repeat (2) @(negedge core_clk);
        chk(selftest_fault, 8'h04);
        m.send(`TDM_CMD_SELF_TEST, 8'h00, 8'h00);
        chk({rsp_out.code, rsp_out.data[0]}, 9'h001);
        m.send(`TDM_CMD_WP_READ, 8'h00, 8'h00);
        chk(m.lat >= 20 && m.lat <= 24, 1'b1);
        health_in = 8'hff;
    endtask
    task t_power;
        m.send(`TDM_CMD_WP_WRITE, 8'h01, 8'h00);
        m.send(`TDM_CMD_FIX_CUR, 8'h01, 8'h00);
        m.send(`TDM_CMD_SELF_TEST, 8'h00, 8'h00);
        chk({rsp_out.code, rsp_out.data[0]}, 9'h000);
        chk({write_protect, fixed_cur_mode}, 2'b11);
        cfg_load_done = 1'b0;
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({link_up, loop_fixed, cfg_load_req, selftest_busy}, 4'h7);
        chk(loop_fixed_ua, `TDM_LOOP_BOOT_UA);
        chk(write_protect, 1'b0);
        chk(fixed_cur_mode, 1'b0);
        sys_rst = 1'b0;
        repeat (70) @(negedge core_clk);
        chk({link_up, cfg_load_req, selftest_busy}, 3'b011);
        cfg_load_done = 1'b1;
        wait_up;
        chk(wn, 32'd2);
        chk(selftest_busy, 1'b0);
    endtask
    task t_rate;
        int n;
        n = 0;
        while (!sample_stb && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!sample_stb && n < 40);
        chk(n, 32'd10);
    endtask
    initial begin
        sys_rst = 1;
        clk_en = 1;
        cfg_load_done = 1;
        health_in = 8'hff;
        bad_count = 0;
        checks_done = 0;
        repeat (20) @(negedge core_clk);
        sys_rst = 0;
        wait_up;
        chk(wn >= 49 && wn < 70, 1'b1);
        t_protect;
        t_damp;
        t_self;
        t_power;
        t_rate;
        final_report;
    end
    initial begin
        #200000;
        bad_count++;
        final_report;
    end
endmodule
